// ### core/csrop_core.sv
/*
  Execution unit for the shift, rotate, multiply, OR, stack and return group.
  Holds accumulator, index X, stack pointer, flags and program counter.
  Assumes: memory read data is valid on mem_rdata one cycle after mem.re,
  writes complete in the cycle mem.we is high, and start comes only while
  busy is low with pc pointing at the opcode.
*/
// Operation
// - Logical right shift moves A or memory right one bit, clears bit 7, old bit 0 to carry.
// - Multiply forms A times the zero-page X byte, pushes the high byte, decrements S, low to A.
// - No-operation only advances the program counter by one, in two cycles.
// - With index mode clear, OR combines A with the operand and writes the result to A.
// - With index mode set, OR writes M(X) OR operand back to M(X), keeping A, updating flags.
// - Push accumulator writes A at the stack pointer, then decrements S, in three cycles.
// - Push flags writes the flags byte at the stack pointer, then decrements S, in three cycles.
// - Pull accumulator increments S, then loads A from the new stack slot, in four cycles.
// - Pull flags increments S, then loads the flags byte from the new slot, in four cycles.
// - Rotate left moves old carry into bit 0 and old bit 7 into carry.
// - Rotate right moves old carry into bit 7 and old bit 0 into carry.
// - Nibble rotate swaps the halves of a zero-page byte, in eight cycles and two bytes.
// - Return from interrupt restores flags, then PC low, then PC high, each after S+1, in six.
// - Return from subroutine restores PC low then high after each S+1, then adds one, in six.
`timescale 1ns/1ns
`default_nettype none

module csrop_core (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    start,
  input  wire logic [7:0]              opcode,
  input  wire logic [7:0]              operand,
  input  wire logic                    reg_load,
  input  wire csrop_pkg::csrop_regs_type reg_in,
  input  wire logic [7:0]              mem_rdata,
  output csrop_pkg::csrop_mem_type     mem,
  output csrop_pkg::csrop_regs_type    regs,
  output logic                         busy,
  output logic                         done,
  output logic                         illegal
);

  // ==========================================================================
  // Helpers
  // Total cycles of an instruction, zero when unsupported
  function automatic logic [4:0] op_cycles(input logic [7:0] op, input logic t);
    unique case (op)
      csrop_pkg::OP_LSR_A, csrop_pkg::OP_ROL_A, csrop_pkg::OP_ROR_A: op_cycles = csrop_pkg::CYC_ACC;
      csrop_pkg::OP_LSR_ZP, csrop_pkg::OP_ROL_ZP,
      csrop_pkg::OP_ROR_ZP:  op_cycles = csrop_pkg::CYC_SH_ZP;
      csrop_pkg::OP_RRF_ZP:  op_cycles = csrop_pkg::CYC_RRF;
      csrop_pkg::OP_NOP:     op_cycles = csrop_pkg::CYC_NOP;
      csrop_pkg::OP_OR_IMM:
        op_cycles = t ? 5'(csrop_pkg::CYC_OR_IMM + csrop_pkg::CYC_T_XTRA) : csrop_pkg::CYC_OR_IMM;
      csrop_pkg::OP_OR_ZP:
        op_cycles = t ? 5'(csrop_pkg::CYC_OR_ZP + csrop_pkg::CYC_T_XTRA) : csrop_pkg::CYC_OR_ZP;
      csrop_pkg::OP_PUSH_A, csrop_pkg::OP_PUSH_PS: op_cycles = csrop_pkg::CYC_PUSH;
      csrop_pkg::OP_PULL_A, csrop_pkg::OP_PULL_PS: op_cycles = csrop_pkg::CYC_PULL;
      csrop_pkg::OP_RET_INT, csrop_pkg::OP_RET_SUB: op_cycles = csrop_pkg::CYC_RET;
      csrop_pkg::OP_MUL_ZPX: op_cycles = csrop_pkg::CYC_MUL;
      default:               op_cycles = 5'h00;
    endcase
  endfunction : op_cycles

  // Instruction length in bytes
  function automatic logic [15:0] op_length(input logic [7:0] op);
    unique case (op)
      csrop_pkg::OP_LSR_ZP, csrop_pkg::OP_ROL_ZP, csrop_pkg::OP_ROR_ZP, csrop_pkg::OP_RRF_ZP,
      csrop_pkg::OP_OR_IMM, csrop_pkg::OP_OR_ZP, csrop_pkg::OP_MUL_ZPX: op_length = 16'h0002;
      default: op_length = 16'h0001;
    endcase
  endfunction : op_length

  // Shift or rotate, returns {carry, result}
  function automatic logic [8:0] shift_op(input logic [7:0] op, input logic [7:0] v,
                                          input logic c);
    if (op == csrop_pkg::OP_LSR_A || op == csrop_pkg::OP_LSR_ZP) begin
      shift_op = {v[0], 1'b0, v[7:1]};
    end else if (op == csrop_pkg::OP_ROL_A || op == csrop_pkg::OP_ROL_ZP) begin
      shift_op = {v[7], v[6:0], c};
    end else begin
      shift_op = {v[0], c, v[7:1]};
    end
  endfunction : shift_op

  // Flags with N and Z taken from a result
  function automatic logic [7:0] set_nz(input logic [7:0] f, input logic [7:0] v);
    set_nz = f;
    set_nz[csrop_pkg::FLAG_N] = v[7];
    set_nz[csrop_pkg::FLAG_Z] = (v == 8'h00);
  endfunction : set_nz

  // Flags after a shift or rotate: N and Z from the result, carry from bit 8
  function automatic logic [7:0] set_nzc(input logic [7:0] f, input logic [8:0] r);
    set_nzc                  = set_nz(f, r[7:0]);
    set_nzc[csrop_pkg::FLAG_C] = r[8];
  endfunction : set_nzc

  // ==========================================================================
  // State
  typedef enum logic {ST_IDLE, ST_RUN} csrop_state_type;

  csrop_state_type state;
  logic [4:0]      cyc;
  logic [4:0]      ncyc;
  logic [7:0]      op;
  logic [7:0]      opnd;
  logic [7:0]      tmp;
  logic [7:0]      a;
  logic [7:0]      x;
  logic [7:0]      s;
  logic [7:0]      ps;
  logic [15:0]     pc;
  logic            run;
  logic            last;
  logic            t;
  logic [4:0]      start_cycles;
  logic [8:0]      sh_acc;
  logic [8:0]      sh_mem;
  logic [15:0]     product;
  logic [7:0]      s_up;

  assign run          = (state == ST_RUN);
  assign last         = run && (cyc == 5'(ncyc - 5'h01));
  assign t            = ps[csrop_pkg::FLAG_T];
  assign start_cycles = op_cycles(opcode, t);
  assign sh_acc       = shift_op(op, a, ps[csrop_pkg::FLAG_C]);
  assign sh_mem       = shift_op(op, mem_rdata, ps[csrop_pkg::FLAG_C]);
  assign product      = 16'(a) * 16'(mem_rdata);
  assign s_up         = 8'(s + 8'h01);

  // Outputs
  assign regs    = '{a: a, x: x, s: s, processor_flags_byte: ps, pc: pc};
  assign busy    = run;
  assign done    = last;

  // ==========================================================================
  // Sequencer: accepts an opcode and counts its cycles
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state   <= ST_IDLE;
      cyc     <= csrop_pkg::RST_CYC;
      ncyc    <= csrop_pkg::RST_CYC;
      op      <= csrop_pkg::OP_NOP;
      opnd    <= 8'h00;
      illegal <= 1'b0;
    end else begin
      illegal <= 1'b0;
      if (state == ST_IDLE) begin
        if (start && start_cycles != 5'h00) begin
          state <= ST_RUN;
          cyc   <= 5'h01;
          ncyc  <= start_cycles;
          op    <= opcode;
          opnd  <= operand;
        end else if (start) begin
          illegal <= 1'b1;                        // Unsupported opcode, nothing changes
        end
      end else if (last) begin
        state <= ST_IDLE;
        cyc   <= csrop_pkg::RST_CYC;
      end else begin
        cyc <= 5'(cyc + 5'h01);
      end
    end
  end

  // ==========================================================================
  // Memory requests per instruction step
  always_comb begin
    mem = '{re: 1'b0, we: 1'b0, addr: 16'h0000, wdata: 8'h00};
    if (run) begin
      unique case (op)
        csrop_pkg::OP_OR_IMM: begin
          if (t && cyc == 5'h01) mem = '{1'b1, 1'b0, {csrop_pkg::ZERO_PAGE, x}, 8'h00};
          if (t && cyc == 5'h03) mem = '{1'b0, 1'b1, {csrop_pkg::ZERO_PAGE, x}, tmp};
        end
        csrop_pkg::OP_OR_ZP: begin
          if (cyc == 5'h01) mem = '{1'b1, 1'b0, {csrop_pkg::ZERO_PAGE, opnd}, 8'h00};
          if (t && cyc == 5'h02) mem = '{1'b1, 1'b0, {csrop_pkg::ZERO_PAGE, x}, 8'h00};
          if (t && cyc == 5'h04) mem = '{1'b0, 1'b1, {csrop_pkg::ZERO_PAGE, x}, tmp};
        end
        csrop_pkg::OP_LSR_ZP, csrop_pkg::OP_ROL_ZP, csrop_pkg::OP_ROR_ZP,
        csrop_pkg::OP_RRF_ZP: begin
          if (cyc == 5'h01) mem = '{1'b1, 1'b0, {csrop_pkg::ZERO_PAGE, opnd}, 8'h00};
          if (cyc == 5'h03) mem = '{1'b0, 1'b1, {csrop_pkg::ZERO_PAGE, opnd}, tmp};
        end
        csrop_pkg::OP_MUL_ZPX: begin
          if (cyc == 5'h01)
            mem = '{1'b1, 1'b0, {csrop_pkg::ZERO_PAGE, 8'(opnd + x)}, 8'h00};
          if (cyc == 5'h03) mem = '{1'b0, 1'b1, {csrop_pkg::STACK_PAGE, s}, tmp};
        end
        csrop_pkg::OP_PUSH_A: begin
          if (cyc == 5'h01) mem = '{1'b0, 1'b1, {csrop_pkg::STACK_PAGE, s}, a};
        end
        csrop_pkg::OP_PUSH_PS: begin
          if (cyc == 5'h01) mem = '{1'b0, 1'b1, {csrop_pkg::STACK_PAGE, s}, ps};
        end
        csrop_pkg::OP_PULL_A, csrop_pkg::OP_PULL_PS: begin
          if (cyc == 5'h01) mem = '{1'b1, 1'b0, {csrop_pkg::STACK_PAGE, s_up}, 8'h00};
        end
        csrop_pkg::OP_RET_INT: begin
          if (cyc >= 5'h01 && cyc <= 5'h03)
            mem = '{1'b1, 1'b0, {csrop_pkg::STACK_PAGE, s_up}, 8'h00};
        end
        csrop_pkg::OP_RET_SUB: begin
          if (cyc >= 5'h01 && cyc <= 5'h02)
            mem = '{1'b1, 1'b0, {csrop_pkg::STACK_PAGE, s_up}, 8'h00};
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Architectural registers and the working byte
  always_ff @(posedge clock) begin
    if (!rstn) begin
      a   <= csrop_pkg::RST_A;
      x   <= csrop_pkg::RST_X;
      s   <= csrop_pkg::RST_S;
      ps  <= csrop_pkg::RST_PS;
      pc  <= csrop_pkg::RST_PC;
      tmp <= 8'h00;
    end else if (!run) begin
      if (reg_load) begin
        a  <= reg_in.a;
        x  <= reg_in.x;
        s  <= reg_in.s;
        ps <= reg_in.processor_flags_byte;
        pc <= reg_in.pc;
      end
    end else begin
      unique case (op)
        csrop_pkg::OP_LSR_A, csrop_pkg::OP_ROL_A, csrop_pkg::OP_ROR_A: begin
          if (cyc == 5'h01) begin
            a  <= sh_acc[7:0];
            ps <= set_nzc(ps, sh_acc);
          end
        end
        csrop_pkg::OP_LSR_ZP, csrop_pkg::OP_ROL_ZP, csrop_pkg::OP_ROR_ZP: begin
          if (cyc == 5'h02) begin
            tmp <= sh_mem[7:0];
            ps  <= set_nzc(ps, sh_mem);
          end
        end
        csrop_pkg::OP_RRF_ZP: begin
          if (cyc == 5'h02) tmp <= {mem_rdata[3:0], mem_rdata[7:4]};
        end
        csrop_pkg::OP_OR_IMM: begin
          if (!t && cyc == 5'h01) begin
            a  <= a | opnd;
            ps <= set_nz(ps, a | opnd);
          end
          if (t && cyc == 5'h02) begin
            tmp <= mem_rdata | opnd;
            ps  <= set_nz(ps, mem_rdata | opnd);
          end
        end
        csrop_pkg::OP_OR_ZP: begin
          if (!t && cyc == 5'h02) begin
            a  <= a | mem_rdata;
            ps <= set_nz(ps, a | mem_rdata);
          end
          if (t && cyc == 5'h02) tmp <= mem_rdata;
          if (t && cyc == 5'h03) begin
            tmp <= tmp | mem_rdata;
            ps  <= set_nz(ps, tmp | mem_rdata);
          end
        end
        csrop_pkg::OP_MUL_ZPX: begin
          if (cyc == 5'h02) begin
            tmp <= product[15:8];
            a   <= product[7:0];
          end
          if (cyc == 5'h04) s <= 8'(s - 8'h01);
        end
        csrop_pkg::OP_PUSH_A, csrop_pkg::OP_PUSH_PS: begin
          if (cyc == 5'h02) s <= 8'(s - 8'h01);
        end
        csrop_pkg::OP_PULL_A: begin
          if (cyc == 5'h01) s <= s_up;
          if (cyc == 5'h02) begin
            a  <= mem_rdata;
            ps <= set_nz(ps, mem_rdata);
          end
        end
        csrop_pkg::OP_PULL_PS: begin
          if (cyc == 5'h01) s <= s_up;
          if (cyc == 5'h02) ps <= mem_rdata;
        end
        csrop_pkg::OP_RET_INT: begin
          if (cyc >= 5'h01 && cyc <= 5'h03) s <= s_up;
          if (cyc == 5'h02) ps <= mem_rdata;
          if (cyc == 5'h03) pc[7:0] <= mem_rdata;
          if (cyc == 5'h04) pc[15:8] <= mem_rdata;
        end
        csrop_pkg::OP_RET_SUB: begin
          if (cyc >= 5'h01 && cyc <= 5'h02) s <= s_up;
          if (cyc == 5'h02) pc[7:0] <= mem_rdata;
          if (cyc == 5'h03) pc[15:8] <= mem_rdata;
          if (cyc == 5'h04) pc <= 16'(pc + 16'h0001);
        end
        default: ;
      endcase
      // Step past the instruction on its last cycle
      if (last && op != csrop_pkg::OP_RET_INT && op != csrop_pkg::OP_RET_SUB) begin
        pc <= 16'(pc + op_length(op));
      end
    end
  end

endmodule : csrop_core

`default_nettype wire

// ### core/csrop_pkg.sv
/*
  Constants and types for the shift, stack, return and logic execution unit
  of an 8-bit core: opcodes, cycle counts, flag positions and reset values.
  Assumes the core delivers each opcode with its second byte already fetched.
*/
`default_nettype none

package csrop_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_LSR_A   = 8'h4a;
  localparam logic [7:0] OP_LSR_ZP  = 8'h46;
  localparam logic [7:0] OP_ROL_A   = 8'h2a;
  localparam logic [7:0] OP_ROL_ZP  = 8'h26;
  localparam logic [7:0] OP_ROR_A   = 8'h6a;
  localparam logic [7:0] OP_ROR_ZP  = 8'h66;
  localparam logic [7:0] OP_RRF_ZP  = 8'h82;
  localparam logic [7:0] OP_NOP     = 8'hea;
  localparam logic [7:0] OP_OR_IMM  = 8'h09;
  localparam logic [7:0] OP_OR_ZP   = 8'h05;
  localparam logic [7:0] OP_PUSH_A  = 8'h48;
  localparam logic [7:0] OP_PUSH_PS = 8'h08;
  localparam logic [7:0] OP_PULL_A  = 8'h68;
  localparam logic [7:0] OP_PULL_PS = 8'h28;
  localparam logic [7:0] OP_RET_INT = 8'h40;
  localparam logic [7:0] OP_RET_SUB = 8'h60;
  localparam logic [7:0] OP_MUL_ZPX = 8'h62;  // Default, change to suit the core

  // ==========================================================================
  // Cycle counts per instruction
  localparam logic [4:0] CYC_ACC    = 5'h02;
  localparam logic [4:0] CYC_SH_ZP  = 5'h05;
  localparam logic [4:0] CYC_RRF    = 5'h08;
  localparam logic [4:0] CYC_NOP    = 5'h02;
  localparam logic [4:0] CYC_OR_IMM = 5'h02;
  localparam logic [4:0] CYC_OR_ZP  = 5'h03;
  localparam logic [4:0] CYC_T_XTRA = 5'h03;  // Extra cycles with index mode set
  localparam logic [4:0] CYC_PUSH   = 5'h03;
  localparam logic [4:0] CYC_PULL   = 5'h04;
  localparam logic [4:0] CYC_RET    = 5'h06;
  localparam logic [4:0] CYC_MUL    = 5'h0f;  // Default, change to suit the core

  // ==========================================================================
  // Flag positions in the processor flags byte
  localparam int FLAG_N = 7;
  localparam int FLAG_T = 5;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  // ==========================================================================
  // Pages and reset values
  localparam logic [7:0]  ZERO_PAGE  = 8'h00;
  localparam logic [7:0]  STACK_PAGE = 8'h01;
  localparam logic [7:0]  RST_A      = 8'h00;
  localparam logic [7:0]  RST_X      = 8'h00;
  localparam logic [7:0]  RST_S      = 8'hff;
  localparam logic [7:0]  RST_PS     = 8'h00;
  localparam logic [15:0] RST_PC     = 16'h0000;
  localparam logic [4:0]  RST_CYC    = 5'h00;

  // Architectural registers seen by the rest of the core
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  s;
    logic [7:0]  processor_flags_byte;
    logic [15:0] pc;
  } csrop_regs_type;

  // Internal memory bus request
  typedef struct packed {
    logic        re;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } csrop_mem_type;

endpackage : csrop_pkg

`default_nettype wire

// ### verification/csrop_properties.sv
/*
  Checker for the shift, stack, return and logic execution unit.
  Assumes it sees only the ports of csrop_core and that the core reset is
  synchronous and active low.
*/
`timescale 1ns/1ns
`default_nettype none

module csrop_properties (
  input wire logic                      clock,
  input wire logic                      rstn,
  input wire logic                      start,
  input wire logic [7:0]                opcode,
  input wire logic [7:0]                operand,
  input wire logic                      reg_load,
  input wire csrop_pkg::csrop_regs_type reg_in,
  input wire logic [7:0]                mem_rdata,
  input wire csrop_pkg::csrop_mem_type  mem,
  input wire csrop_pkg::csrop_regs_type regs,
  input wire logic                      busy,
  input wire logic                      done,
  input wire logic                      illegal
);
  // ==========================================================================
  // Opcode acceptance
  logic take;
  assign take = start && !busy && !reg_load;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Timing and results
  nop_only_pc_a: assert property (take && opcode == csrop_pkg::OP_NOP |=> done ##1
    (regs.pc == $past(regs.pc, 2) + 16'h0001 && regs.a == $past(regs.a, 2)))
    else $error("nop result wrong");
  push_slot_a: assert property (take && (opcode == csrop_pkg::OP_PUSH_A ||
    opcode == csrop_pkg::OP_PUSH_PS) |=> (mem.we && mem.addr == {csrop_pkg::STACK_PAGE,
    $past(regs.s)}) ##1 done ##1 (regs.s == $past(regs.s, 3) - 8'h01))
    else $error("push sequence wrong");
  pull_slot_a: assert property (take && (opcode == csrop_pkg::OP_PULL_A ||
    opcode == csrop_pkg::OP_PULL_PS) |=> (mem.re && mem.addr == {csrop_pkg::STACK_PAGE,
    $past(regs.s) + 8'h01}) ##2 done) else $error("pull sequence wrong");
  lsr_acc_a: assert property (take && opcode == csrop_pkg::OP_LSR_A |=> done ##1
    (regs.a == ($past(regs.a, 2) >> 1) && regs.processor_flags_byte[0] == $past(regs.a[0], 2)))
    else $error("right shift wrong");
  rol_acc_a: assert property (take && opcode == csrop_pkg::OP_ROL_A |=> done ##1
    (regs.a == {$past(regs.a[6:0], 2), $past(regs.processor_flags_byte[0], 2)} &&
    regs.processor_flags_byte[0] == $past(regs.a[7], 2))) else $error("rotate left wrong");
  ror_acc_a: assert property (take && opcode == csrop_pkg::OP_ROR_A |=> done ##1
    (regs.a == {$past(regs.processor_flags_byte[0], 2), $past(regs.a[7:1], 2)} &&
    regs.processor_flags_byte[0] == $past(regs.a[0], 2))) else $error("rotate right wrong");
  or_imm_a: assert property (take && opcode == csrop_pkg::OP_OR_IMM &&
    !regs.processor_flags_byte[csrop_pkg::FLAG_T] |=> done ##1
    (regs.a == ($past(regs.a, 2) | $past(operand, 2)) &&
    regs.processor_flags_byte[csrop_pkg::FLAG_Z] == (regs.a == 8'h00)))
    else $error("or immediate wrong");
  nibble_swap_a: assert property (take && opcode == csrop_pkg::OP_RRF_ZP |=>
    (mem.re && mem.addr == {csrop_pkg::ZERO_PAGE, $past(operand)}) ##2
    (mem.we && mem.wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}) ##4 done)
    else $error("nibble rotate wrong");
  ret_int_a: assert property (take && opcode == csrop_pkg::OP_RET_INT |=>
    !done [*4] ##1 done ##1 (regs.s == $past(regs.s, 6) + 8'h03))
    else $error("return from interrupt wrong");
  ret_sub_a: assert property (take && opcode == csrop_pkg::OP_RET_SUB |=>
    !done [*4] ##1 done ##1 (regs.s == $past(regs.s, 6) + 8'h02))
    else $error("return from subroutine wrong");
  mul_push_a: assert property (take && opcode == csrop_pkg::OP_MUL_ZPX |=>
    ##13 done ##1 (regs.s == $past(regs.s, 15) - 8'h01)) else $error("multiply wrong");

  // Main scenarios reached
  cover property (take && opcode == csrop_pkg::OP_NOP);
  cover property (take && opcode == csrop_pkg::OP_RET_INT);
  cover property (take && opcode == csrop_pkg::OP_MUL_ZPX);
  cover property (illegal);
endmodule : csrop_properties

bind csrop_core csrop_properties u_csrop_properties (.clock(clock), .rstn(rstn), .start(start),
  .opcode(opcode), .operand(operand), .reg_load(reg_load), .reg_in(reg_in),
  .mem_rdata(mem_rdata), .mem(mem), .regs(regs), .busy(busy), .done(done), .illegal(illegal));

`default_nettype wire

// ### verification/tb.sv
/*
  Self-checking bench for csrop_core: random register loads and operands,
  every opcode per round, stack edge values, back-to-back and illegal starts.
  Assumes a memory with read latency one, modelled here.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic                      clock;
  logic                      rstn;
  logic                      start;
  logic [7:0]                opcode;
  logic [7:0]                operand;
  logic                      reg_load;
  csrop_pkg::csrop_regs_type reg_in;
  logic [7:0]                mem_rdata;
  csrop_pkg::csrop_mem_type  mem;
  csrop_pkg::csrop_regs_type regs;
  logic                      busy;
  logic                      done;
  logic                      illegal;
  int                        failures;
  int                        cmp_count;
  int                        cyc;
  int                        seed;
  logic [7:0]                mem_arr [0:65535];
  logic [7:0]                ops [0:16];
  csrop_pkg::csrop_regs_type cur;
  csrop_pkg::csrop_regs_type r;

  csrop_core u_csrop_core (.clock(clock), .rstn(rstn), .start(start), .opcode(opcode),
    .operand(operand), .reg_load(reg_load), .reg_in(reg_in), .mem_rdata(mem_rdata),
    .mem(mem), .regs(regs), .busy(busy), .done(done), .illegal(illegal));

  // ==========================================================================
  // Clock, memory with one cycle read latency, hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (mem.we) mem_arr[mem.addr] <= mem.wdata;
    mem_rdata <= mem.re ? mem_arr[mem.addr] : ~mem_rdata;  // No stale data when idle
    cyc++;
    if (cyc == 30000) begin
      failures++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Checking helpers and expected-state model
  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] nz(input logic [7:0] f, input logic [7:0] v);
    nz = f;
    nz[csrop_pkg::FLAG_N] = v[7];
    nz[csrop_pkg::FLAG_Z] = (v == 8'h00);
  endfunction : nz

  function automatic void predict(input logic [7:0] op, input logic [7:0] zz,
    inout csrop_pkg::csrop_regs_type e, output logic [15:0] wa, output logic [7:0] wd,
    output bit wr, output int n);
    logic [7:0]  m;
    logic [7:0]  s0;
    logic [7:0]  res;
    logic        cy;
    logic [15:0] p;
    bit          sh;
    m = mem_arr[{8'h00, zz}];
    s0 = op[3] ? e.a : m;
    wr = 1'b0;
    wa = {8'h00, zz};
    wd = 8'h00;
    n = 2;
    sh = 1'b1;
    e.pc = e.pc + 16'h0001;
    // Shifts and rotates, accumulator or zero-page form
    case (op)
      csrop_pkg::OP_LSR_A, csrop_pkg::OP_LSR_ZP: {res, cy} = {1'b0, s0};
      csrop_pkg::OP_ROL_A, csrop_pkg::OP_ROL_ZP: {cy, res} = {s0, e.processor_flags_byte[0]};
      csrop_pkg::OP_ROR_A, csrop_pkg::OP_ROR_ZP: {res, cy} = {e.processor_flags_byte[0], s0};
      default: sh = 1'b0;
    endcase
    if (sh) begin
      e.processor_flags_byte = nz(e.processor_flags_byte, res);
      e.processor_flags_byte[0] = cy;
      if (op[3]) e.a = res;
      else begin
        {wr, wd, n} = {1'b1, res, 32'd5};
        e.pc = e.pc + 16'h0001;
      end
    end
    // Remaining operations
    case (op)
      csrop_pkg::OP_RRF_ZP: begin
        {wr, wd, n} = {1'b1, m[3:0], m[7:4], 32'd8};
        e.pc = e.pc + 16'h0001;
      end
      csrop_pkg::OP_OR_IMM, csrop_pkg::OP_OR_ZP: begin
        res = (op == csrop_pkg::OP_OR_IMM) ? zz : m;
        n = (op == csrop_pkg::OP_OR_IMM) ? 2 : 3;
        e.pc = e.pc + 16'h0001;
        if (e.processor_flags_byte[csrop_pkg::FLAG_T]) begin
          res = res | mem_arr[{8'h00, e.x}];
          {wr, wa, wd} = {1'b1, 8'h00, e.x, res};
          n = n + 3;
        end else begin
          res = res | e.a;
          e.a = res;
        end
        e.processor_flags_byte = nz(e.processor_flags_byte, res);
      end
      csrop_pkg::OP_PUSH_A, csrop_pkg::OP_PUSH_PS: begin
        {wr, wa, n} = {1'b1, 8'h01, e.s, 32'd3};
        wd = (op == csrop_pkg::OP_PUSH_A) ? e.a : e.processor_flags_byte;
        e.s = e.s - 8'h01;
      end
      csrop_pkg::OP_PULL_A, csrop_pkg::OP_PULL_PS: begin
        e.s = e.s + 8'h01;
        n = 4;
        if (op == csrop_pkg::OP_PULL_A) begin
          e.a = mem_arr[{8'h01, e.s}];
          e.processor_flags_byte = nz(e.processor_flags_byte, e.a);
        end else e.processor_flags_byte = mem_arr[{8'h01, e.s}];
      end
      csrop_pkg::OP_RET_INT: begin
        e.processor_flags_byte = mem_arr[{8'h01, e.s + 8'h01}];
        e.pc = {mem_arr[{8'h01, e.s + 8'h03}], mem_arr[{8'h01, e.s + 8'h02}]};
        e.s = e.s + 8'h03;
        n = 6;
      end
      csrop_pkg::OP_RET_SUB: begin
        e.pc = {mem_arr[{8'h01, e.s + 8'h02}], mem_arr[{8'h01, e.s + 8'h01}]} + 16'h0001;
        e.s = e.s + 8'h02;
        n = 6;
      end
      csrop_pkg::OP_MUL_ZPX: begin
        p = e.a * mem_arr[{8'h00, zz + e.x}];
        {wr, wa, wd, n} = {1'b1, 8'h01, e.s, p[15:8], 32'd15};
        e.s = e.s - 8'h01;
        e.a = p[7:0];
        e.pc = e.pc + 16'h0001;
      end
      default: ;
    endcase
  endfunction : predict

  // ==========================================================================
  // Drivers: register load and one instruction with its checks
  task automatic load(input csrop_pkg::csrop_regs_type v);
    reg_in = v;
    reg_load = 1'b1;
    @(posedge clock);
    #1 reg_load = 1'b0;
    cur = v;
  endtask : load

  task automatic run_op(input logic [7:0] op, input logic [7:0] zz);
    csrop_pkg::csrop_regs_type e;
    logic [15:0]               wa;
    logic [7:0]                wd;
    bit                        wr;
    int                        n;
    int                        k;
    e = cur;
    predict(op, zz, e, wa, wd, wr, n);
    {opcode, operand, start} = {op, zz, 1'b1};
    @(posedge clock);
    #1 start = 1'b0;
    chk("busy", busy, 1'b1);
    k = 1;
    while (done !== 1'b1 && k < 40) begin
      @(posedge clock);
      #1 k++;
    end
    chk("cycles", k + 1, n);
    @(posedge clock);
    #1 chk("regs", regs, e);
    if (wr) chk("memory", mem_arr[wa], wd);
    cur = e;
  endtask : run_op

  // ==========================================================================
  // Main sequence
  initial begin
    {clock, start, opcode, operand, reg_load, reg_in, mem_rdata} = '0;
    {rstn, failures, cmp_count, cyc} = '0;
    seed = 66563;
    ops = '{csrop_pkg::OP_LSR_A, csrop_pkg::OP_LSR_ZP, csrop_pkg::OP_ROL_A,
      csrop_pkg::OP_ROL_ZP, csrop_pkg::OP_ROR_A, csrop_pkg::OP_ROR_ZP, csrop_pkg::OP_RRF_ZP,
      csrop_pkg::OP_NOP, csrop_pkg::OP_OR_IMM, csrop_pkg::OP_OR_ZP, csrop_pkg::OP_PUSH_A,
      csrop_pkg::OP_PUSH_PS, csrop_pkg::OP_PULL_A, csrop_pkg::OP_PULL_PS,
      csrop_pkg::OP_RET_INT, csrop_pkg::OP_RET_SUB, csrop_pkg::OP_MUL_ZPX};
    for (int i = 0; i < 512; i++) mem_arr[i] = $random(seed);
    repeat (8) @(posedge clock);
    #1 rstn = 1'b1;
    cur = {csrop_pkg::RST_A, csrop_pkg::RST_X, csrop_pkg::RST_S, csrop_pkg::RST_PS,
      csrop_pkg::RST_PC};
    chk("reset", regs, cur);
    // Unsupported opcode pulses illegal and leaves state alone
    {opcode, start} = {8'hff, 1'b1};
    @(posedge clock);
    #1 start = 1'b0;
    chk("illegal", illegal, 1'b1);
    @(posedge clock);
    #1 chk("regs", regs, cur);
    // Rounds over every opcode; first rounds force stack and flag corners
    for (int rd = 0; rd < 16; rd++) begin
      for (int i = 0; i < 17; i++) begin
        r = 40'({$random(seed), $random(seed)});
        if (rd == 0) r.s = 8'hff;
        if (rd == 1) r.s = 8'h00;
        if (rd == 2) r.a = 8'h00;
        if (rd == 3) r.processor_flags_byte[csrop_pkg::FLAG_T] = 1'b1;
        load(r);
        run_op(ops[i], $random(seed));
        run_op(ops[$unsigned($random(seed)) % 17], $random(seed));  // Back to back
      end
    end
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
